//--- atr_defs.svh
`ifndef ATR_DEFS_SVH
`define ATR_DEFS_SVH
// Register indices on the plain register port
`define ATR_ADDR_CHAN_GO 3'h0
`define ATR_ADDR_FMT 3'h1
`define ATR_ADDR_TRIG 3'h2
`define ATR_ADDR_RES_HI 3'h3
`define ATR_ADDR_RES_LO 3'h4
`define ATR_ADDR_IRQ_STAT 3'h5
`define ATR_ADDR_IRQ_MASK 3'h6
// Implemented-bit masks per control register
`define ATR_MASK_CHAN_GO 8'h7F
`define ATR_MASK_FMT 8'hF3
`define ATR_MASK_TRIG 8'hF0
// Field positions
`define ATR_BIT_ON 0
`define ATR_BIT_GO 1
`define ATR_BIT_JUSTIFY 7
`define ATR_TRIG_LSB 4
`define ATR_TRIG_MSB 7
// Trigger source codes
`define ATR_TRIG_NONE 4'h0
`define ATR_TRIG_TMR0 4'h3
`define ATR_TRIG_TMR1 4'h4
`define ATR_TRIG_TMR2 4'h5
`define ATR_TRIG_CMP1 4'h6
`define ATR_TRIG_CMP2 4'h7
`define ATR_TRIG_LC1 4'h8
`define ATR_TRIG_LC2 4'h9
// Reset values
`define ATR_RST_CTRL 8'h00
// Interrupt status bits
`define ATR_IRQ_DONE 0
`define ATR_IRQ_TMR0 1
`define ATR_IRQ_TMR1 2
`define ATR_IRQ_MASK 8'h07
// Conversion: one result bit per this many clocks
`define ATR_BIT_CYCLES 4'h8
`define ATR_RES_BITS 10
`endif

//--- atr_pkg.sv
package atr_pkg;
   // Register port request
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } atr_bus_t;
   // Auto-trigger event lines
   typedef struct packed {
      logic timer_zero_rollover;
      logic timer_one_rollover;
      logic timer_two_period_hit;
      logic comparator_one_synced_out;
      logic comparator_two_synced_out;
      logic logic_cell_one_output;
      logic logic_cell_two_output;
   } atr_src_t;
   // Converter sequencer states
   typedef enum logic [1:0] {
      ATR_IDLE = 2'b00,
      ATR_CONV = 2'b01,
      ATR_LOAD = 2'b11
   } atr_state_t;
endpackage : atr_pkg

//--- atr_adc_ctrl.sv
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "atr_defs.svh"
// What this block does
// - Decode four-bit trigger source select codes
// - Trigger select in bits 7:4, reset zero
// - Start only on rising edge of source
// - Timer rollover trigger still sets timer flag
// - Unimplemented control bits read zero
// - Left justify: high byte holds bits 9:2
// - Left justify: low byte bits 7:6 hold 1:0
// - Right justify: high byte bits 1:0 hold 9:8
// - Right justify: low byte holds bits 7:0
// - Result bytes writable, not reset
// - Hold capacitor never discharged between conversions
// - Trigger edge sets go flag in hardware
// - Completion clears go, sets done, loads
// - Unused justified bits load as zero
// - Go cleared aborts, fills with last bit
module atr_adc_ctrl (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Register port
   input wire atr_pkg::atr_bus_t bus_in,
   output logic [7:0] rdata_out,
   // Trigger event lines from other peripherals
   input wire atr_pkg::atr_src_t src_in,
   // Comparator decision from the analog core
   input wire logic cmp_in,
   // Analog front-end control
   output logic [4:0] channel_select_out,
   output logic converter_on_out,
   output logic sample_out,
   output logic [9:0] dac_code_out,
   // Timer interrupt flag set pulses
   output logic tmr0_flag_set_out,
   output logic tmr1_flag_set_out,
   // Interrupt
   output logic irq_out
);
   import atr_pkg::*;

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] chan_go_r; // Channel, go, on
   logic [7:0] fmt_r; // Justify, clock, reference
   logic [7:0] trig_r; // Trigger select in upper nibble
   logic [7:0] res_hi_r; // Result high byte
   logic [7:0] res_lo_r; // Result low byte
   logic [7:0] irq_stat_r; // Sticky events
   logic [7:0] irq_mask_r; // Event enables
   logic [1:0] sync_a_r; // Delayed synced timer rollover levels for flag edge detect
   logic [6:0] src_s1_r; // Source sync stage one
   logic [6:0] src_s2_r; // Source sync stage two
   logic src_sel_r; // Selected source, delayed
   logic cmp_s1_r; // Comparator sync stage one
   logic cmp_s2_r; // Comparator sync stage two
   atr_state_t state_r; // Sequencer state
   logic [3:0] bitcnt_r; // Bit being decided
   logic [3:0] clkcnt_r; // Clocks within a bit
   logic [9:0] sar_r; // Successive-approximation word
   logic last_bit_r; // Last decided bit value
   logic abort_r; // Load came from an abort
   logic [9:0] fill_mask_r; // Bits already decided

   // ****************************************
   // Combinational helpers
   // ****************************************
   logic wr_chan, wr_fmt, wr_trig, wr_hi, wr_lo, wr_stat, wr_mask;
   logic src_sel; // Selected synced source level
   logic trig_pulse; // Single-cycle start request
   logic busy; // Conversion running
   logic done_evt; // Completion or abort load
   logic [9:0] final_res; // Value to be loaded
   logic [7:0] irq_set; // Events this cycle

   assign wr_chan = bus_in.wr && (bus_in.addr == `ATR_ADDR_CHAN_GO);
   assign wr_fmt = bus_in.wr && (bus_in.addr == `ATR_ADDR_FMT);
   assign wr_trig = bus_in.wr && (bus_in.addr == `ATR_ADDR_TRIG);
   assign wr_hi = bus_in.wr && (bus_in.addr == `ATR_ADDR_RES_HI);
   assign wr_lo = bus_in.wr && (bus_in.addr == `ATR_ADDR_RES_LO);
   assign wr_stat = bus_in.wr && (bus_in.addr == `ATR_ADDR_IRQ_STAT);
   assign wr_mask = bus_in.wr && (bus_in.addr == `ATR_ADDR_IRQ_MASK);
   assign busy = (state_r != ATR_IDLE);

   // Source select mux, reserved codes give a constant low
   always_comb begin
      unique case (trig_r[`ATR_TRIG_MSB:`ATR_TRIG_LSB])
         `ATR_TRIG_TMR0: src_sel = src_s2_r[6];
         `ATR_TRIG_TMR1: src_sel = src_s2_r[5];
         `ATR_TRIG_TMR2: src_sel = src_s2_r[4];
         `ATR_TRIG_CMP1: src_sel = src_s2_r[3];
         `ATR_TRIG_CMP2: src_sel = src_s2_r[2];
         `ATR_TRIG_LC1: src_sel = src_s2_r[1];
         `ATR_TRIG_LC2: src_sel = src_s2_r[0];
         default: src_sel = 1'b0;
      endcase
   end

   // Rising edge only, ignored while converting or off
   assign trig_pulse = src_sel && !src_sel_r && !busy && chan_go_r[`ATR_BIT_ON];

   assign done_evt = (state_r == ATR_LOAD);

   // Abort fills undecided bits with last decided bit
   assign final_res = abort_r ? ((sar_r & fill_mask_r) | ({10{last_bit_r}} & ~fill_mask_r)) : sar_r;

   // Event vector for sticky status
   assign irq_set = {5'h00,
                     tmr1_flag_set_out,
                     tmr0_flag_set_out,
                     done_evt};

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Two flops on every trigger source and comparator
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         src_s1_r <= 7'h00;
         src_s2_r <= 7'h00;
         cmp_s1_r <= 1'b0;
         cmp_s2_r <= 1'b0;
      end else begin
         src_s1_r <= src_in;
         src_s2_r <= src_s1_r;
         cmp_s1_r <= cmp_in;
         cmp_s2_r <= cmp_s1_r;
      end
   end

   // Delayed selected level for the edge detector
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         src_sel_r <= 1'b0;
      end else begin
         src_sel_r <= src_sel;
      end
   end

   // Timer rollovers keep setting their own flag
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sync_a_r <= 2'b00;
         tmr0_flag_set_out <= 1'b0;
         tmr1_flag_set_out <= 1'b0;
      end else begin
         sync_a_r <= src_s2_r[6:5];
         tmr0_flag_set_out <= src_s2_r[6] && !sync_a_r[1];
         tmr1_flag_set_out <= src_s2_r[5] && !sync_a_r[0];
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   // Channel, on, and go; go also driven by hardware
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         chan_go_r <= `ATR_RST_CTRL;
      end else begin
         if (wr_chan) begin
            chan_go_r <= bus_in.wdata & `ATR_MASK_CHAN_GO;
         end
         if (trig_pulse) begin
            chan_go_r[`ATR_BIT_GO] <= 1'b1;
         end else if (state_r == ATR_CONV && bitcnt_r == 4'h0 && clkcnt_r == 4'h0) begin
            chan_go_r[`ATR_BIT_GO] <= 1'b0;
         end
      end
   end

   // Format, clock and reference
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fmt_r <= `ATR_RST_CTRL;
      end else if (wr_fmt) begin
         fmt_r <= bus_in.wdata & `ATR_MASK_FMT;
      end
   end

   // Trigger select, low nibble unimplemented
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         trig_r <= `ATR_RST_CTRL;
      end else if (wr_trig) begin
         trig_r <= bus_in.wdata & `ATR_MASK_TRIG;
      end
   end

   // ****************************************
   // Conversion sequencer
   // ****************************************
   // Go flag starts; clearing it mid-way aborts
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_r <= ATR_IDLE;
         bitcnt_r <= 4'h0;
         clkcnt_r <= 4'h0;
         sar_r <= 10'h000;
         last_bit_r <= 1'b0;
         abort_r <= 1'b0;
         fill_mask_r <= 10'h000;
      end else begin
         unique case (state_r)
            ATR_IDLE: begin
               abort_r <= 1'b0;
               if (chan_go_r[`ATR_BIT_GO] && chan_go_r[`ATR_BIT_ON]) begin
                  // Hold node kept; no discharge before sampling
                  state_r <= ATR_CONV;
                  bitcnt_r <= 4'(`ATR_RES_BITS - 1);
                  clkcnt_r <= `ATR_BIT_CYCLES - 4'h1;
                  sar_r <= 10'h200;
                  fill_mask_r <= 10'h000;
                  // Abort before any decision fills with zero
                  last_bit_r <= 1'b0;
               end
            end
            ATR_CONV: begin
               if (!chan_go_r[`ATR_BIT_GO] || !chan_go_r[`ATR_BIT_ON]) begin
                  state_r <= ATR_LOAD;
                  abort_r <= 1'b1;
                  sar_r <= sar_r & fill_mask_r;
               end else if (clkcnt_r != 4'h0) begin
                  clkcnt_r <= clkcnt_r - 4'h1;
               end else begin
                  // Decide this bit from the comparator
                  sar_r[bitcnt_r] <= cmp_s2_r;
                  last_bit_r <= cmp_s2_r;
                  fill_mask_r[bitcnt_r] <= 1'b1;
                  clkcnt_r <= `ATR_BIT_CYCLES - 4'h1;
                  if (bitcnt_r == 4'h0) begin
                     state_r <= ATR_LOAD;
                  end else begin
                     sar_r[bitcnt_r - 4'h1] <= 1'b1;
                     bitcnt_r <= bitcnt_r - 4'h1;
                  end
               end
            end
            ATR_LOAD: begin
               state_r <= ATR_IDLE;
            end
            default: begin
               state_r <= ATR_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Result registers, no reset
   // ****************************************
   // Loaded justified on completion, else software writes
   always_ff @(posedge clk_in) begin
      if (done_evt) begin
         if (fmt_r[`ATR_BIT_JUSTIFY]) begin
            res_hi_r <= {6'h00, final_res[9:8]};
            res_lo_r <= final_res[7:0];
         end else begin
            res_hi_r <= final_res[9:2];
            res_lo_r <= {final_res[1:0], 6'h00};
         end
      end else begin
         if (wr_hi) begin
            res_hi_r <= bus_in.wdata;
         end
         if (wr_lo) begin
            res_lo_r <= bus_in.wdata;
         end
      end
   end

   // ****************************************
   // Interrupt status and mask
   // ****************************************
   // Write one clears; a new event wins over the clear
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_stat_r <= 8'h00;
         irq_mask_r <= 8'h00;
      end else begin
         irq_stat_r <= ((irq_stat_r & ~(wr_stat ? bus_in.wdata : 8'h00)) | irq_set) & `ATR_IRQ_MASK;
         if (wr_mask) begin
            irq_mask_r <= bus_in.wdata & `ATR_IRQ_MASK;
         end
      end
   end

   // Level interrupt output
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_stat_r & irq_mask_r);
      end
   end

   // ****************************************
   // Read port and front-end outputs
   // ****************************************
   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_out <= 8'h00;
      end else if (bus_in.rd) begin
         unique case (bus_in.addr)
            `ATR_ADDR_CHAN_GO: rdata_out <= chan_go_r;
            `ATR_ADDR_FMT: rdata_out <= fmt_r;
            `ATR_ADDR_TRIG: rdata_out <= trig_r;
            `ATR_ADDR_RES_HI: rdata_out <= res_hi_r;
            `ATR_ADDR_RES_LO: rdata_out <= res_lo_r;
            `ATR_ADDR_IRQ_STAT: rdata_out <= irq_stat_r;
            `ATR_ADDR_IRQ_MASK: rdata_out <= irq_mask_r;
            default: rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

   // Analog controls registered from control state
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         channel_select_out <= 5'h00;
         converter_on_out <= 1'b0;
         sample_out <= 1'b0;
         dac_code_out <= 10'h000;
      end else begin
         channel_select_out <= chan_go_r[6:2];
         converter_on_out <= chan_go_r[`ATR_BIT_ON];
         // Sampling while idle and on; software owns the acquisition wait
         sample_out <= chan_go_r[`ATR_BIT_ON] && !busy;
         dac_code_out <= sar_r;
      end
   end

endmodule : atr_adc_ctrl

//--- atr_adc_ctrl_chk.sv
`timescale 1ns/100ps
`include "atr_defs.svh"
// ************************************
// Port checker for the converter block
// ************************************
module atr_adc_ctrl_chk (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Register port
   input wire atr_pkg::atr_bus_t bus_in,
   input wire logic [7:0] rdata_out,
   // Event lines and analog side
   input wire atr_pkg::atr_src_t src_in,
   input wire logic cmp_in,
   input wire logic [4:0] channel_select_out,
   input wire logic converter_on_out,
   input wire logic sample_out,
   input wire logic [9:0] dac_code_out,
   // Flags and interrupt
   input wire logic tmr0_flag_set_out,
   input wire logic tmr1_flag_set_out,
   input wire logic irq_out
);
   import atr_pkg::*;
   logic [7:0] fmt_r;  // Shadow of the format register
   logic [7:0] trig_r;  // Shadow of the trigger register
   // Shadows follow software writes, masked to implemented bits
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fmt_r <= 8'h00;
         trig_r <= 8'h00;
      end else if (bus_in.wr && bus_in.addr == `ATR_ADDR_FMT) begin
         fmt_r <= bus_in.wdata & `ATR_MASK_FMT;
      end else if (bus_in.wr && bus_in.addr == `ATR_ADDR_TRIG) begin
         trig_r <= bus_in.wdata & `ATR_MASK_TRIG;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   property p_trig_rb;
      $past(bus_in.rd) && $past(bus_in.addr) == `ATR_ADDR_TRIG |-> rdata_out == $past(trig_r);
   endproperty
   a_trig_rb: assert property (p_trig_rb) else $error("trigger select read back wrong");
   property p_fmt_rb;
      $past(bus_in.rd) && $past(bus_in.addr) == `ATR_ADDR_FMT |-> rdata_out == $past(fmt_r);
   endproperty
   a_fmt_rb: assert property (p_fmt_rb) else $error("format read back wrong");
   property p_unmap;
      $past(bus_in.rd) && $past(bus_in.addr) == 3'h7 |-> rdata_out == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_idle_rd;
      !$past(bus_in.rd) |-> rdata_out == 8'h00;
   endproperty
   a_idle_rd: assert property (p_idle_rd) else $error("read data outside read slot");
   property p_t0;
      $rose(src_in.timer_zero_rollover) |-> ##[1:4] tmr0_flag_set_out;
   endproperty
   a_t0: assert property (p_t0) else $error("timer zero flag not set");
   property p_t1;
      $rose(src_in.timer_one_rollover) |-> ##[1:4] tmr1_flag_set_out;
   endproperty
   a_t1: assert property (p_t1) else $error("timer one flag not set");
   property p_pulse;
      tmr0_flag_set_out |=> !tmr0_flag_set_out;
   endproperty
   a_pulse: assert property (p_pulse) else $error("flag pulse too long");
   property p_smp_off;
      !converter_on_out |-> !sample_out;
   endproperty
   a_smp_off: assert property (p_smp_off) else $error("sampling while off");
   property p_conv;
      $fell(sample_out) && converter_on_out |-> ##[1:100] (sample_out || !converter_on_out);
   endproperty
   a_conv: assert property (p_conv) else $error("conversion did not end");
   // Main scenarios reached
   c_t0: cover property (tmr0_flag_set_out);
   c_irq: cover property ($rose(irq_out));
   c_conv: cover property ($fell(sample_out));
endmodule : atr_adc_ctrl_chk

//--- atr_adc_ctrl_tb.sv
`timescale 1ns/100ps
`include "atr_defs.svh"
`define CHK(nm, e, g) begin \
   checks++; \
   if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
   end \
end
// ******************************
// Bench for the converter block
// ******************************
module atr_adc_ctrl_tb;
   import atr_pkg::*;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   atr_bus_t bus = '0;  // Register port request
   atr_src_t src = '0;  // Event lines
   logic cmp_in = 1'b0;  // Fake comparator
   logic [7:0] rdata_out;
   logic [4:0] chan;
   logic on, smp, t0f, t1f, irq;
   logic [9:0] dac;
   logic [9:0] target = 10'h000;  // Level of the fake input
   logic [7:0] d;  // Last read data
   int n_mismatch = 0;
   int checks = 0;
   atr_adc_ctrl dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .bus_in(bus), .rdata_out(rdata_out), .src_in(src),
      .cmp_in(cmp_in), .channel_select_out(chan), .converter_on_out(on), .sample_out(smp), .dac_code_out(dac),
      .tmr0_flag_set_out(t0f), .tmr1_flag_set_out(t1f), .irq_out(irq));
   // Clock
   initial forever #4 clk_in = ~clk_in;
   // Comparator says input at or above trial word
   always @(posedge clk_in) cmp_in <= (dac <= target);
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      bus <= '0;
      @(posedge clk_in);
   endtask : wr
   task automatic rd(input logic [2:0] a);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      bus <= '0;
      @(posedge clk_in);
      // Read data still stands at this edge
      d = rdata_out;
   endtask : rd
   task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string nm);
      rd(a);
      `CHK(nm, e, d)
   endtask : rdc
   // Poll go until it drops, bounded
   task automatic wait_idle();
      for (int i = 0; i < 100; i++) begin
         rd(`ATR_ADDR_CHAN_GO);
         if (d[`ATR_BIT_GO] === 1'b0) break;
      end
      `CHK("go idle", 1'b0, d[`ATR_BIT_GO])
   endtask : wait_idle
   task automatic t_regs();
      rdc(`ATR_ADDR_TRIG, 8'h00, "trig reset");
      wr(`ATR_ADDR_TRIG, 8'hFF);
      rdc(`ATR_ADDR_TRIG, 8'hF0, "trig rw");
      wr(`ATR_ADDR_FMT, 8'hFF);
      rdc(`ATR_ADDR_FMT, 8'hF3, "fmt rw");
      wr(`ATR_ADDR_CHAN_GO, 8'hFC);
      rdc(`ATR_ADDR_CHAN_GO, 8'h7C, "chan rw");
      `CHK("chan out", 5'h1F, chan)
      wr(3'h7, 8'hFF);
      rdc(3'h7, 8'h00, "unmapped");
      wr(`ATR_ADDR_RES_HI, 8'hA5);
      wr(`ATR_ADDR_RES_LO, 8'h5A);
      rdc(`ATR_ADDR_RES_HI, 8'hA5, "res hi rw");
      rdc(`ATR_ADDR_RES_LO, 8'h5A, "res lo rw");
      wr(`ATR_ADDR_TRIG, 8'h00);
   endtask : t_regs
   // Software start, justified result, done flag and interrupt
   task automatic t_conv(input logic rj, input logic [9:0] v, input logic mk);
      target = v;
      wr(`ATR_ADDR_IRQ_MASK, {7'h00, mk});
      wr(`ATR_ADDR_FMT, {rj, 7'h00});
      wr(`ATR_ADDR_CHAN_GO, 8'h01);
      repeat (40) @(posedge clk_in);  // Acquisition wait
      wr(`ATR_ADDR_CHAN_GO, 8'h03);
      wait_idle();
      `CHK("dac final", v, dac)
      rdc(`ATR_ADDR_RES_HI, rj ? {6'h00, v[9:8]} : v[9:2], "res hi");
      rdc(`ATR_ADDR_RES_LO, rj ? v[7:0] : {v[1:0], 6'h00}, "res lo");
      rdc(`ATR_ADDR_IRQ_STAT, 8'h01, "done flag");
      `CHK("irq", mk, irq)
      wr(`ATR_ADDR_IRQ_STAT, 8'hFF);
      rdc(`ATR_ADDR_IRQ_STAT, 8'h00, "done clear");
      `CHK("irq clear", 1'b0, irq)
   endtask : t_conv
   // Every trigger code, level hold and retrigger while busy
   task automatic t_trig();
      atr_src_t s;
      target = 10'h155;
      wr(`ATR_ADDR_CHAN_GO, 8'h01);
      for (int c = 0; c < 16; c++) begin
         s = (c >= 3 && c <= 9) ? atr_src_t'(7'h40 >> (c - 3)) : atr_src_t'(7'h7F);
         wr(`ATR_ADDR_TRIG, 8'(c << 4));
         src <= s;
         repeat (8) @(posedge clk_in);
         rd(`ATR_ADDR_CHAN_GO);
         `CHK("trig go", (c >= 3 && c <= 9), d[`ATR_BIT_GO])
         src <= '0;
         repeat (4) @(posedge clk_in);
         src <= s;
         rd(`ATR_ADDR_IRQ_STAT);
         if (c == 3 || c == 4) `CHK("timer flag", 1'b1, d[c - 2])
         wait_idle();
         rd(`ATR_ADDR_CHAN_GO);
         `CHK("no retrigger", 1'b0, d[`ATR_BIT_GO])
         src <= '0;
         wr(`ATR_ADDR_IRQ_STAT, 8'hFF);
         repeat (4) @(posedge clk_in);
      end
      wr(`ATR_ADDR_TRIG, 8'h00);
   endtask : t_trig
   // Abort after two decided bits: rest copies the last bit
   task automatic t_abort();
      target = 10'h2AA;
      wr(`ATR_ADDR_FMT, 8'h80);
      wr(`ATR_ADDR_CHAN_GO, 8'h03);
      repeat (19) @(posedge clk_in);
      wr(`ATR_ADDR_CHAN_GO, 8'h01);
      wait_idle();
      rdc(`ATR_ADDR_RES_HI, 8'h02, "abort hi");
      rdc(`ATR_ADDR_RES_LO, 8'h00, "abort lo");
   endtask : t_abort
   // Mid-run reset: controls clear, result bytes kept
   task automatic t_rst();
      wr(`ATR_ADDR_TRIG, 8'h90);
      resetn_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      rdc(`ATR_ADDR_TRIG, 8'h00, "trig reset again");
      rdc(`ATR_ADDR_RES_HI, 8'h02, "res hi kept");
      rdc(`ATR_ADDR_RES_LO, 8'h00, "res lo kept");
   endtask : t_rst
   task automatic results();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   // Main sequence
   initial begin
      repeat (8) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      t_regs();
      t_conv(1'b1, 10'h3A5, 1'b0);
      t_conv(1'b0, 10'h2C3, 1'b1);
      t_trig();
      t_abort();
      t_rst();
      results();
   end
   // Watchdog
   initial begin
      #200000;
      n_mismatch++;
      results();
   end
endmodule : atr_adc_ctrl_tb
bind atr_adc_ctrl atr_adc_ctrl_chk chk_u (.clk_in(clk_in), .resetn_in(resetn_in), .bus_in(bus_in),
   .rdata_out(rdata_out), .src_in(src_in), .cmp_in(cmp_in), .channel_select_out(channel_select_out),
   .converter_on_out(converter_on_out), .sample_out(sample_out), .dac_code_out(dac_code_out),
   .tmr0_flag_set_out(tmr0_flag_set_out), .tmr1_flag_set_out(tmr1_flag_set_out), .irq_out(irq_out));
